// ===== src/usbcc_params.svh
// register map, field positions, reset values and timing constants
`ifndef USBCC_PARAMS_SVH
`define USBCC_PARAMS_SVH
`define USBCC_OFS_CONTROL   8'h00
`define USBCC_OFS_CONFIG    8'h04
`define USBCC_ADDR_W        8
`define USBCC_CTL_PPRST     6
`define USBCC_CTL_SE0       5
`define USBCC_CTL_PKTOFF    4
`define USBCC_CTL_ENABLE    3
`define USBCC_CTL_RESUME    2
`define USBCC_CTL_SUSPEND   1
`define USBCC_CFG_EYE       7
`define USBCC_CFG_OEMON     6
`define USBCC_CFG_PULLUP    4
`define USBCC_CFG_XDIS      3
`define USBCC_CFG_FSPEED    2
`define USBCC_CFG_PPM_HI    1
`define USBCC_CFG_PPM_LO    0
`define USBCC_RST_BYTE      8'h00
`define USBCC_RST_WORD      32'h0000_0000
`define USBCC_PPM_NONE      2'h0
`define USBCC_CLK_PS        20000
`define USBCC_FS_BIT_PS     83333
`define USBCC_LS_BIT_PS     666667
`define USBCC_FS_BIT_CYC    (`USBCC_FS_BIT_PS / `USBCC_CLK_PS)
`define USBCC_LS_BIT_CYC    (`USBCC_LS_BIT_PS / `USBCC_CLK_PS)
`define USBCC_DIV_W         6
`endif

// ===== src/usbcc_pkg.sv
// types shared by the link control block
package usbcc_pkg;
    typedef enum logic [1:0] {
        USBCC_LINE_SE0 = 2'h0,
        USBCC_LINE_LS  = 2'h1,
        USBCC_LINE_FS  = 2'h2,
        USBCC_LINE_ERR = 2'h3
    } usbcc_line_t;
    typedef enum logic [3:0] {
        USBCC_TX_IDLE   = 4'h1,
        USBCC_TX_ENGINE = 4'h2,
        USBCC_TX_RESUME = 4'h4,
        USBCC_TX_EYE    = 4'h8
    } usbcc_txmode_t;
    typedef struct packed {
        logic pingpong_pointer_reset;
        logic packet_disable_flag;
        logic module_enable;
        logic resume_signaling;
        logic suspend_control;
    } usbcc_ctrl_t;
    typedef struct packed {
        logic       eye_pattern_test_enable;
        logic       output_enable_monitor;
        logic       onchip_pullup_enable;
        logic       transceiver_disable;
        logic       full_speed_select;
        logic [1:0] pingpong_mode_field;
    } usbcc_cfg_t;
endpackage

// ===== src/usbcc_link_ctrl.sv
// link control/configuration registers and transceiver interface
`timescale 1ns/10ps
`include "usbcc_params.svh"

module usbcc_link_ctrl
    import usbcc_pkg::*;
(
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_NRST,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    input  wire logic        I_SETUP_TOKEN,
    input  wire logic        I_SIE_TX_VALID,
    input  wire logic        I_SIE_TX_DATA,
    input  wire logic        I_SIE_TX_SE0,
    output logic             O_SIE_ENABLE,
    output logic             O_SIE_CLK_EN,
    output logic             O_LOW_POWER,
    output logic             O_PKT_PROC_EN,
    output logic             O_PP_PTR_CLEAR,
    output logic      [1:0]  O_PP_MODE,
    output logic             O_SIE_FULL_SPEED,
    output logic             O_SIE_RX_DATA,
    output usbcc_line_t      O_SIE_LINE_STATE,
    input  wire logic        I_INT_DP,
    input  wire logic        I_INT_DM,
    output logic             O_INT_XCVR_EN,
    output logic             O_INT_TX_DP,
    output logic             O_INT_TX_DM,
    output logic             O_INT_TX_OE,
    output logic             O_PULLUP_DP,
    output logic             O_PULLUP_DM,
    input  wire logic        I_PLUS_LINE,
    input  wire logic        I_MINUS_LINE,
    input  wire logic        I_RECEIVE_DIFF,
    output logic             O_DRIVE_PLUS,
    output logic             O_DRIVE_MINUS,
    output logic             O_TRANSMIT_ENABLE_N
);

    usbcc_ctrl_t                    ctrl;
    usbcc_cfg_t                     cfg;
    logic                           se0_live;
    logic                           wr_pend;
    logic [`USBCC_ADDR_W-1:0]       wr_addr;
    logic                           enable_d;
    usbcc_txmode_t                  txmode;
    usbcc_txmode_t                  next_txmode;
    logic [`USBCC_DIV_W-1:0]        div_cnt;
    logic                           bit_tick;
    logic                           eye_phase;
    logic                           addr_ok;
    logic                           wr_ctl;
    logic                           wr_cfg;
    logic [`USBCC_ADDR_W-1:0]       rd_addr;
    logic [7:0]                     ctl_rd;
    logic [7:0]                     cfg_rd;
    logic [1:0]                     line_in;
    logic                           enabled;
    logic                           ext_sel;
    logic                           drv_on;
    logic                           drv_plus;
    logic                           drv_minus;
    logic [`USBCC_DIV_W-1:0]        div_max;

    // bus slave: zero wait states, write data lands one cycle after address
    assign addr_ok = I_HSEL & I_HTRANS[1] & I_HREADY;
    assign rd_addr = I_HADDR[`USBCC_ADDR_W-1:0];
    assign wr_ctl  = wr_pend & (wr_addr == `USBCC_OFS_CONTROL);
    assign wr_cfg  = wr_pend & (wr_addr == `USBCC_OFS_CONFIG);

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            wr_pend <= 1'b0;
            wr_addr <= `USBCC_RST_BYTE;
        end else begin
            wr_pend <= addr_ok & I_HWRITE;
            wr_addr <= rd_addr;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_HRDATA    <= `USBCC_RST_WORD;
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
        end else begin
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
            if (addr_ok && !I_HWRITE) begin
                unique case (rd_addr)
                    `USBCC_OFS_CONTROL: O_HRDATA <= {24'h00_0000, ctl_rd};
                    `USBCC_OFS_CONFIG:  O_HRDATA <= {24'h00_0000, cfg_rd};
                    default:            O_HRDATA <= `USBCC_RST_WORD;
                endcase
            end
        end
    end

    always_comb begin
        ctl_rd = `USBCC_RST_BYTE;
        ctl_rd[`USBCC_CTL_PPRST]   = ctrl.pingpong_pointer_reset;
        ctl_rd[`USBCC_CTL_SE0]     = se0_live;
        ctl_rd[`USBCC_CTL_PKTOFF]  = ctrl.packet_disable_flag;
        ctl_rd[`USBCC_CTL_ENABLE]  = ctrl.module_enable;
        ctl_rd[`USBCC_CTL_RESUME]  = ctrl.resume_signaling;
        ctl_rd[`USBCC_CTL_SUSPEND] = ctrl.suspend_control;
        cfg_rd = `USBCC_RST_BYTE;
        cfg_rd[`USBCC_CFG_EYE]    = cfg.eye_pattern_test_enable;
        cfg_rd[`USBCC_CFG_OEMON]  = cfg.output_enable_monitor;
        cfg_rd[`USBCC_CFG_PULLUP] = cfg.onchip_pullup_enable;
        cfg_rd[`USBCC_CFG_XDIS]   = cfg.transceiver_disable;
        cfg_rd[`USBCC_CFG_FSPEED] = cfg.full_speed_select;
        cfg_rd[`USBCC_CFG_PPM_HI:`USBCC_CFG_PPM_LO] =
            cfg.pingpong_mode_field;
    end

    // control register; packet-disable is set by hardware, cleared by
    // software, and a setup token in the clearing cycle wins
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            ctrl <= '0;
        end else begin
            if (wr_ctl) begin
                ctrl.pingpong_pointer_reset <= I_HWDATA[`USBCC_CTL_PPRST];
                ctrl.module_enable    <= I_HWDATA[`USBCC_CTL_ENABLE];
                ctrl.resume_signaling <= I_HWDATA[`USBCC_CTL_RESUME];
                ctrl.suspend_control  <= I_HWDATA[`USBCC_CTL_SUSPEND];
            end
            if (I_SETUP_TOKEN && ctrl.module_enable) begin
                ctrl.packet_disable_flag <= 1'b1;
            end else if (wr_ctl && !I_HWDATA[`USBCC_CTL_PKTOFF]) begin
                ctrl.packet_disable_flag <= 1'b0;
            end
        end
    end

    // configuration register; all fields plainly writable
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cfg <= '0;
        end else if (wr_cfg) begin
            cfg.eye_pattern_test_enable <= I_HWDATA[`USBCC_CFG_EYE];
            cfg.output_enable_monitor   <= I_HWDATA[`USBCC_CFG_OEMON];
            cfg.onchip_pullup_enable    <= I_HWDATA[`USBCC_CFG_PULLUP];
            cfg.transceiver_disable     <= I_HWDATA[`USBCC_CFG_XDIS];
            cfg.full_speed_select       <= I_HWDATA[`USBCC_CFG_FSPEED];
            cfg.pingpong_mode_field     <=
                I_HWDATA[`USBCC_CFG_PPM_HI:`USBCC_CFG_PPM_LO];
        end
    end

    assign enabled = ctrl.module_enable;
    assign ext_sel = cfg.transceiver_disable;
    assign line_in = ext_sel ? {I_PLUS_LINE, I_MINUS_LINE}
                             : {I_INT_DP, I_INT_DM};

    // live bus condition, refreshed every cycle
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            se0_live <= 1'b0;
            enable_d <= 1'b0;
        end else begin
            se0_live <= (line_in == USBCC_LINE_SE0);
            enable_d <= enabled;
        end
    end

    // bit-rate enable; low speed is a 33-cycle divider, full speed a 4-cycle one
    assign div_max = cfg.full_speed_select
        ? `USBCC_DIV_W'(`USBCC_FS_BIT_CYC - 1)
        : `USBCC_DIV_W'(`USBCC_LS_BIT_CYC - 1);
    assign bit_tick = (div_cnt == div_max);

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            div_cnt <= '0;
        end else if (bit_tick || txmode != USBCC_TX_EYE) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + `USBCC_DIV_W'(1);
        end
    end

    // transmit source: suspend and detach win over every other source
    always_comb begin
        next_txmode = USBCC_TX_IDLE;
        if (!enabled || ctrl.suspend_control) begin
            next_txmode = USBCC_TX_IDLE;
        end else if (cfg.eye_pattern_test_enable) begin
            next_txmode = USBCC_TX_EYE;
        end else if (ctrl.resume_signaling) begin
            next_txmode = USBCC_TX_RESUME;
        end else if (!ctrl.packet_disable_flag && I_SIE_TX_VALID) begin
            next_txmode = USBCC_TX_ENGINE;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            txmode <= USBCC_TX_IDLE;
        end else begin
            txmode <= next_txmode;
        end
    end

    // eye pattern starts with minus high: J at low speed, K at full speed
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            eye_phase <= 1'b0;
        end else if (txmode != USBCC_TX_EYE) begin
            eye_phase <= 1'b0;
        end else if (bit_tick) begin
            eye_phase <= ~eye_phase;
        end
    end

    // line driver value; only complementary or all-low, never both high
    always_comb begin
        drv_on    = 1'b0;
        drv_plus  = cfg.full_speed_select;
        drv_minus = ~cfg.full_speed_select;
        unique case (txmode)
            USBCC_TX_IDLE: begin
                drv_on = 1'b0;
            end
            USBCC_TX_ENGINE: begin
                drv_on    = 1'b1;
                drv_plus  = I_SIE_TX_DATA & ~I_SIE_TX_SE0;
                drv_minus = ~I_SIE_TX_DATA & ~I_SIE_TX_SE0;
            end
            USBCC_TX_RESUME: begin
                drv_on    = 1'b1;
                drv_plus  = ~cfg.full_speed_select;
                drv_minus = cfg.full_speed_select;
            end
            USBCC_TX_EYE: begin
                drv_on    = 1'b1;
                drv_plus  = eye_phase;
                drv_minus = ~eye_phase;
            end
        endcase
    end

    // engine-facing outputs
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_SIE_ENABLE     <= 1'b0;
            O_SIE_CLK_EN     <= 1'b0;
            O_LOW_POWER      <= 1'b0;
            O_PKT_PROC_EN    <= 1'b0;
            O_PP_PTR_CLEAR   <= 1'b0;
            O_PP_MODE        <= `USBCC_PPM_NONE;
            O_SIE_FULL_SPEED <= 1'b0;
            O_SIE_RX_DATA    <= 1'b0;
            O_SIE_LINE_STATE <= USBCC_LINE_SE0;
        end else begin
            O_SIE_ENABLE  <= enabled;
            O_SIE_CLK_EN  <= enabled & ~ctrl.suspend_control;
            O_LOW_POWER   <= enabled & ctrl.suspend_control;
            // status-window reads stay open; only token handling stops
            O_PKT_PROC_EN <= enabled & ~ctrl.packet_disable_flag;
            O_PP_PTR_CLEAR <= (enabled & ~enable_d)
                | (enabled & ctrl.pingpong_pointer_reset
                   & (cfg.pingpong_mode_field != `USBCC_PPM_NONE));
            O_PP_MODE        <= cfg.pingpong_mode_field;
            O_SIE_FULL_SPEED <= cfg.full_speed_select;
            O_SIE_RX_DATA    <= ext_sel ? I_RECEIVE_DIFF : I_INT_DP;
            O_SIE_LINE_STATE <= usbcc_line_t'(line_in);
        end
    end

    // transceiver-facing outputs; the unselected transceiver stays quiet, bar O_TRANSMIT_ENABLE_N when output_enable_monitor is set
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_INT_XCVR_EN       <= 1'b0;
            O_INT_TX_DP         <= 1'b0;
            O_INT_TX_DM         <= 1'b0;
            O_INT_TX_OE         <= 1'b0;
            O_PULLUP_DP         <= 1'b0;
            O_PULLUP_DM         <= 1'b0;
            O_DRIVE_PLUS        <= 1'b0;
            O_DRIVE_MINUS       <= 1'b0;
            O_TRANSMIT_ENABLE_N <= 1'b1;
        end else begin
            O_INT_XCVR_EN <= enabled & ~ext_sel;
            O_INT_TX_DP   <= ~ext_sel & drv_on & drv_plus;
            O_INT_TX_DM   <= ~ext_sel & drv_on & drv_minus;
            O_INT_TX_OE   <= ~ext_sel & drv_on;
            // pull-up stays while suspended so the device remains attached
            O_PULLUP_DP <= enabled & ~ext_sel & cfg.onchip_pullup_enable
                & cfg.full_speed_select;
            O_PULLUP_DM <= enabled & ~ext_sel & cfg.onchip_pullup_enable
                & ~cfg.full_speed_select;
            O_DRIVE_PLUS  <= ext_sel & drv_on & drv_plus;
            O_DRIVE_MINUS <= ext_sel & drv_on & drv_minus;
            // monitor-only with internal transceiver; costs no pin function
            O_TRANSMIT_ENABLE_N <= ~(drv_on
                & (ext_sel | cfg.output_enable_monitor));
        end
    end

endmodule // usbcc_link_ctrl

// ===== verif/usbcc_link_ctrl_assertions.sv
// concurrent checks on the link control block ports
`timescale 1ns/10ps
module usbcc_link_ctrl_checker
    import usbcc_pkg::*;
(
    input wire logic        I_SYS_CLK,
    input wire logic        I_NRST,
    input wire logic        I_SETUP_TOKEN,
    input wire logic        I_PLUS_LINE,
    input wire logic        I_MINUS_LINE,
    input wire logic        I_RECEIVE_DIFF,
    input wire logic        O_SIE_ENABLE,
    input wire logic        O_SIE_CLK_EN,
    input wire logic        O_LOW_POWER,
    input wire logic        O_PKT_PROC_EN,
    input wire logic        O_PP_PTR_CLEAR,
    input wire logic        O_SIE_FULL_SPEED,
    input wire logic        O_SIE_RX_DATA,
    input wire usbcc_line_t O_SIE_LINE_STATE,
    input wire logic        O_INT_XCVR_EN,
    input wire logic        O_PULLUP_DP,
    input wire logic        O_PULLUP_DM,
    input wire logic        O_DRIVE_PLUS,
    input wire logic        O_DRIVE_MINUS,
    input wire logic        O_TRANSMIT_ENABLE_N
);
    logic ext_on;
    // register outputs lag the pins by one edge, so levels are held two
    assign ext_on = O_SIE_ENABLE && !O_INT_XCVR_EN;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);
    a_pair_legal: assert property (!(O_DRIVE_PLUS && O_DRIVE_MINUS))
        else $error("drive pair shows 11");
    a_idle_pair: assert property (O_TRANSMIT_ENABLE_N |->
        !O_DRIVE_PLUS && !O_DRIVE_MINUS) else $error("pair not idle");
    a_detach_quiet: assert property (!O_SIE_ENABLE &&
        $past(!O_SIE_ENABLE) |-> O_TRANSMIT_ENABLE_N && !O_INT_XCVR_EN
        && !O_PULLUP_DP && !O_PULLUP_DM && !O_SIE_CLK_EN)
        else $error("active while detached");
    a_suspend_idle: assert property (O_LOW_POWER &&
        $past(O_LOW_POWER) |-> O_SIE_ENABLE && !O_SIE_CLK_EN
        && O_TRANSMIT_ENABLE_N) else $error("suspend not idle");
    a_setup_stops: assert property (I_SETUP_TOKEN ##1 O_SIE_ENABLE
        |-> ##[0:2] !O_PKT_PROC_EN) else $error("setup kept traffic");
    a_enable_clear: assert property ($rose(O_SIE_ENABLE) |->
        ##[0:1] (O_PP_PTR_CLEAR || $past(O_PP_PTR_CLEAR)))
        else $error("no pointer clear on enable");
    a_pullup_side: assert property (O_PULLUP_DP || O_PULLUP_DM |->
        O_INT_XCVR_EN && O_PULLUP_DP == O_SIE_FULL_SPEED
        && O_PULLUP_DM != O_SIE_FULL_SPEED) else $error("pull-up wrong");
    a_line_decode: assert property (ext_on && $past(ext_on) |->
        O_SIE_LINE_STATE == $past({I_PLUS_LINE, I_MINUS_LINE}))
        else $error("line state wrong");
    a_rx_stream: assert property (ext_on && $past(ext_on) |->
        O_SIE_RX_DATA == $past(I_RECEIVE_DIFF)) else $error("rx wrong");
endmodule // usbcc_link_ctrl_checker

bind usbcc_link_ctrl usbcc_link_ctrl_checker u_checker (
    .I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .I_SETUP_TOKEN(I_SETUP_TOKEN),
    .I_PLUS_LINE(I_PLUS_LINE), .I_MINUS_LINE(I_MINUS_LINE),
    .I_RECEIVE_DIFF(I_RECEIVE_DIFF), .O_SIE_ENABLE(O_SIE_ENABLE),
    .O_SIE_CLK_EN(O_SIE_CLK_EN), .O_LOW_POWER(O_LOW_POWER),
    .O_PKT_PROC_EN(O_PKT_PROC_EN), .O_PP_PTR_CLEAR(O_PP_PTR_CLEAR),
    .O_SIE_FULL_SPEED(O_SIE_FULL_SPEED), .O_SIE_RX_DATA(O_SIE_RX_DATA),
    .O_SIE_LINE_STATE(O_SIE_LINE_STATE), .O_INT_XCVR_EN(O_INT_XCVR_EN),
    .O_PULLUP_DP(O_PULLUP_DP), .O_PULLUP_DM(O_PULLUP_DM),
    .O_DRIVE_PLUS(O_DRIVE_PLUS), .O_DRIVE_MINUS(O_DRIVE_MINUS),
    .O_TRANSMIT_ENABLE_N(O_TRANSMIT_ENABLE_N));

// ===== verif/usbcc_xcvr_model.sv
// behavioural bus transceiver and line model for the link block
`timescale 1ns/10ps
module usbcc_xcvr_model (
    input  wire logic       i_te_n,
    input  wire logic       i_dplus,
    input  wire logic       i_dminus,
    input  wire logic       i_int_oe,
    input  wire logic       i_int_dp,
    input  wire logic       i_int_dm,
    input  wire logic [1:0] i_state,
    output logic            o_plus,
    output logic            o_minus,
    output logic            o_rx_diff,
    output logic            o_int_dp,
    output logic            o_int_dm
);
    // while the device drives, the receivers see its own drive pair
    always_comb begin
        {o_plus, o_minus} = i_te_n ? i_state : {i_dplus, i_dminus};
        {o_int_dp, o_int_dm} = i_int_oe ? {i_int_dp, i_int_dm} : i_state;
        // only meaningful on J or K; at SE0 it simply follows plus
        o_rx_diff = o_plus;
    end
endmodule // usbcc_xcvr_model

// ===== verif/testbench.sv
// self-checking bench for the link control block
`timescale 1ns/10ps
`include "usbcc_params.svh"
module testbench
    import usbcc_pkg::*;
;
    typedef struct packed {
        logic [7:0] cfg;
        logic [5:0] exp;
    } usbcc_row_t;
    localparam logic [7:0] CTL = `USBCC_OFS_CONTROL;
    localparam logic [7:0] CFG = `USBCC_OFS_CONFIG;
    // config, then {int xcvr, pull D+, pull D-, full speed, mode}
    usbcc_row_t  rows [4] = '{'{8'h14, 6'h34}, '{8'h11, 6'h29},
                              '{8'h1e, 6'h06}, '{8'h23, 6'h23}};
    logic        clk, nrst, hsel, hwrite, setup, txv, txd, txse0;
    logic [1:0]  htrans, st;
    logic [31:0] haddr, hwdata, rdat;
    int          err_count = 0, num_checks = 0, n;
    wire  [31:0] hrdata;
    wire  [1:0]  ppm;
    wire  usbcc_line_t lst;
    wire         hrdy, hresp, sie_en, clk_en, lowp, pproc, ppclr, fs, rxd;
    wire         int_en, itdp, itdm, itoe, pu_dp, pu_dm, dplus, dminus;
    wire         te_n, plus, minus, rx_diff, idp, idm;

    usbcc_link_ctrl dut (
        .I_SYS_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HRDATA(hrdata),
        .O_HREADYOUT(hrdy), .O_HRESP(hresp), .I_SETUP_TOKEN(setup),
        .I_SIE_TX_VALID(txv), .I_SIE_TX_DATA(txd), .I_SIE_TX_SE0(txse0),
        .O_SIE_ENABLE(sie_en), .O_SIE_CLK_EN(clk_en), .O_LOW_POWER(lowp),
        .O_PKT_PROC_EN(pproc), .O_PP_PTR_CLEAR(ppclr), .O_PP_MODE(ppm),
        .O_SIE_FULL_SPEED(fs), .O_SIE_RX_DATA(rxd), .O_SIE_LINE_STATE(lst),
        .I_INT_DP(idp), .I_INT_DM(idm), .O_INT_XCVR_EN(int_en),
        .O_INT_TX_DP(itdp), .O_INT_TX_DM(itdm), .O_INT_TX_OE(itoe),
        .O_PULLUP_DP(pu_dp), .O_PULLUP_DM(pu_dm), .I_PLUS_LINE(plus),
        .I_MINUS_LINE(minus), .I_RECEIVE_DIFF(rx_diff), .O_DRIVE_PLUS(dplus),
        .O_DRIVE_MINUS(dminus), .O_TRANSMIT_ENABLE_N(te_n));
    usbcc_xcvr_model u_xcvr (
        .i_te_n(te_n), .i_dplus(dplus), .i_dminus(dminus), .i_int_oe(itoe),
        .i_int_dp(itdp), .i_int_dm(itdm), .i_state(st), .o_plus(plus),
        .o_minus(minus), .o_rx_diff(rx_diff), .o_int_dp(idp), .o_int_dm(idm));

    task automatic end_of_test();
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // one single word transfer; the slave may stretch either phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hrdy !== 1'b1);
        rdat = hrdata;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        end_of_test();
    end
    initial begin
        {nrst, hsel, hwrite, setup, txv, txd, txse0} = '0;
        {htrans, haddr, hwdata} = '0;
        st = 2'h2;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        cyc(1);
        chk(32'({hrdy, hresp, te_n, sie_en, pu_dp, int_en}), 32'h28);
        xfer(0, CFG, 8'h00);
        chk(rdat, 32'h0000_0000);
        xfer(1, 8'h08, 8'hff);
        xfer(0, 8'h08, 8'h00);
        chk(rdat, 32'h0000_0000);
        st <= 2'h0;
        xfer(0, CTL, 8'h00);
        chk(rdat, 32'h0000_0020);
        st <= 2'h2;
        xfer(0, CTL, 8'h00);
        chk(rdat, 32'h0000_0000);
        foreach (rows[i]) begin
            xfer(1, CFG, rows[i].cfg);
            xfer(1, CTL, 8'h08);
            cyc(2);
            chk(32'({int_en, pu_dp, pu_dm, fs, ppm}), 32'(rows[i].exp));
            xfer(0, CFG, 8'h00);
            chk(rdat, 32'(rows[i].cfg & 8'hdf));
            xfer(1, CTL, 8'h00);
        end
        xfer(1, CFG, 8'h0c);
        xfer(1, CTL, 8'h18);
        setup <= 1'b1;
        @(posedge clk);
        setup <= 1'b0;
        txv <= 1'b1;
        txd <= 1'b1;
        cyc(4);
        chk(32'({pproc, te_n}), 32'h1);
        xfer(0, CTL, 8'h00);
        chk(rdat, 32'h0000_0018);
        xfer(1, CTL, 8'h08);
        cyc(3);
        chk(32'({pproc, te_n, dplus, dminus}), 32'ha);
        chk(32'({rxd, lst}), 32'h6);
        @(posedge clk);
        txse0 <= 1'b1;
        cyc(3);
        chk(32'({te_n, dplus, dminus, lst}), 32'h0);
        @(posedge clk);
        txse0 <= 1'b0;
        txv <= 1'b0;
        // suspend only once the line has gone idle
        xfer(1, CTL, 8'h0a);
        txv <= 1'b1;
        cyc(3);
        chk(32'({sie_en, lowp, clk_en, te_n, dplus, dminus}), 32'h34);
        xfer(1, CTL, 8'h0c);
        txv <= 1'b0;
        cyc(3);
        chk(32'({te_n, dplus, dminus}), 32'h1);
        // held far shorter than a real wake-up, which would outlast the run
        cyc(20);
        chk(32'({te_n, dplus, dminus}), 32'h1);
        xfer(1, CTL, 8'h08);
        cyc(3);
        chk(32'({te_n, dplus, dminus}), 32'h4);
        xfer(1, CFG, 8'h8c);
        n = 0;
        while (te_n !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        chk(32'({dplus, dminus}), 32'h1);
        cyc(4);
        chk(32'({dplus, dminus}), 32'h2);
        xfer(1, CFG, 8'h0c);
        cyc(3);
        chk(32'(te_n), 32'h1);
        xfer(1, CTL, 8'h48);
        cyc(3);
        chk(32'(ppclr), 32'h0);
        xfer(1, CTL, 8'h00);
        xfer(1, CFG, 8'h0e);
        xfer(1, CTL, 8'h48);
        cyc(3);
        chk(32'(ppclr), 32'h1);
        xfer(0, CTL, 8'h00);
        chk(rdat, 32'h0000_0048);
        xfer(1, CTL, 8'h00);
        xfer(1, CFG, 8'h44);
        xfer(1, CTL, 8'h0c);
        cyc(3);
        chk(32'({te_n, itoe, itdp, itdm}), 32'h5);
        xfer(1, CTL, 8'h00);
        xfer(1, CFG, 8'h08);
        xfer(1, CTL, 8'h0c);
        cyc(3);
        chk(32'({te_n, dplus, dminus}), 32'h2);
        xfer(1, CTL, 8'h08);
        xfer(1, CFG, 8'h88);
        n = 0;
        while (te_n !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        chk(32'({dplus, dminus}), 32'h1);
        cyc(33);
        chk(32'({dplus, dminus}), 32'h2);
        @(posedge clk);
        nrst <= 1'b0;
        cyc(2);
        chk(32'({hrdy, te_n, sie_en, dplus, dminus, ppclr}), 32'h30);
        @(posedge clk);
        nrst <= 1'b1;
        xfer(0, CFG, 8'h00);
        chk(rdat, 32'h0000_0000);
        xfer(0, CTL, 8'h00);
        chk(rdat, 32'h0000_0000);
        end_of_test();
    end
endmodule // testbench
